//--- adc_spi_frame.sv
// Purpose: serial frame control for the ADC port in three interface modes
// Assumes: pins synchronous to clock_i; serial edges seen as clock enables
// Notes: one device word per frame; commands leave after frame completion
`timescale 1ns/1ns
module adc_spi_frame (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic interface_mode_pin_i,
   input wire logic interface_mode_pin_float_i,
   input wire logic internal_clock_source_select_i,
   input wire logic [adc_spi_pkg::DIV_W-1:0] internal_clock_divider_i,
   input wire logic [adc_spi_pkg::DIV_W-1:0] modulator_clock_divider_i,
   input wire logic sync_loss_clear_i,
   input wire adc_spi_pkg::spi_in_type spi_i,
   output adc_spi_pkg::spi_out_type spi_o,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [adc_spi_pkg::FRAME_BITS-1:0] sample_data_i,
   output logic command_valid_o,
   output logic [adc_spi_pkg::FRAME_BITS-1:0] command_word_o,
   output logic sync_loss_flag_o,
   output logic filter_reset_o,
   output logic modulator_tick_o,
   output adc_spi_pkg::interface_mode_type interface_mode_o
);
   import adc_spi_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic div_hit(input logic [DIV_W-1:0] cnt,
                                    input logic [DIV_W-1:0] div);
      div_hit = (cnt == div);
   endfunction

   function automatic interface_mode_type strap_mode(input logic level,
                                                     input logic floating);
      if (floating) begin
         strap_mode = MODE_SLAVE;
      end else if (level) begin
         strap_mode = MODE_ASYNC;
      end else begin
         strap_mode = MODE_MASTER;
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   interface_mode_type mode;
   logic mode_locked;
   logic sclk_prev;
   logic cs_prev;
   logic data_ready_strobe_in_prev;
   logic [DIV_W-1:0] icnt;
   logic [DIV_W-1:0] mcnt;
   logic [PHASE_W-1:0] phase;
   logic sclk_gen;
   logic frame_on;
   logic [FRAME_BITS-1:0] tx_sh;
   logic [CNT_W-1:0] tx_cnt;
   logic [FRAME_BITS-1:0] rx_sh;
   logic [CNT_W-1:0] rx_cnt;
   logic dout_q;
   logic dout_oe_q;
   logic data_ready_strobe_q;
   logic cmd_valid_q;
   logic [FRAME_BITS-1:0] cmd_word_q;
   logic sync_loss;
   logic filt_rst_q;
   logic fifo_valid;
   logic [FRAME_BITS-1:0] fifo_data;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire is_master = mode_locked && (mode == MODE_MASTER);
   wire is_slave = mode_locked && (mode == MODE_SLAVE);
   wire is_async = mode_locked && (mode == MODE_ASYNC);
   wire sclk_rise_pin = spi_i.sclk && !sclk_prev;
   wire sclk_fall_pin = !spi_i.sclk && sclk_prev;
   wire cs_rise = spi_i.cs_n && !cs_prev;
   wire data_ready_strobe_in_fall = !spi_i.data_ready_strobe && data_ready_strobe_in_prev;
   wire use_sclk_internal_clock = is_slave && internal_clock_source_select_i;
   wire internal_clock_tick = use_sclk_internal_clock ? sclk_rise_pin
                    : (mode_locked && div_hit(icnt, internal_clock_divider_i));
   wire mod_tick = internal_clock_tick && div_hit(mcnt, modulator_clock_divider_i);
   wire update_tick = mod_tick && (phase == PHASE_LAST);
   // falls accepted on the update tick or while the phase is zero
   wire data_ready_strobe_in_ok = (phase == PHASE_ZERO) || update_tick;
   wire resync = is_slave && data_ready_strobe_in_fall && !data_ready_strobe_in_ok;
   wire m_rise = is_master && internal_clock_tick && !sclk_gen;
   wire m_fall = is_master && internal_clock_tick && sclk_gen;
   wire sel = !spi_i.cs_n && mode_locked && !is_master;
   wire rise_ev = is_master ? m_rise : (sel && sclk_rise_pin);
   wire fall_ev = is_master ? m_fall : (sel && sclk_fall_pin);
   wire active = is_master ? frame_on : sel;
   wire rx_full = (rx_cnt == FRAME_BITS_CNT);
   wire tx_full = (tx_cnt == FRAME_BITS_CNT);
   wire master_end = is_master && frame_on && rx_full;
   wire slave_end = !is_master && mode_locked && cs_rise;
   wire frame_busy = is_master ? frame_on : (sel || cs_rise || is_slave && !spi_i.cs_n);
   wire load = update_tick && fifo_valid && !frame_busy;

   // ------------------------------------------------------------
   // sample buffer
   // ------------------------------------------------------------
   // words wait here while a frame is busy; a full buffer stalls the source
   sample_fifo #(
      .WIDTH(FRAME_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .in_data_i(sample_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(load),
      .out_data_o(fifo_data)
   );

   // ------------------------------------------------------------
   // mode strap and pin history
   // ------------------------------------------------------------
   // strap caught on first edge after release
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         mode_locked <= 1'b0;
         mode <= MODE_ASYNC;
      end else if (!mode_locked) begin
         mode_locked <= 1'b1;
         mode <= strap_mode(interface_mode_pin_i, interface_mode_pin_float_i);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         sclk_prev <= SCLK_RESET;
         cs_prev <= CS_N_RESET;
         data_ready_strobe_in_prev <= DATA_READY_STROBE_RESET;
      end else begin
         sclk_prev <= spi_i.sclk;
         cs_prev <= spi_i.cs_n;
         data_ready_strobe_in_prev <= spi_i.data_ready_strobe;
      end
   end

   // ------------------------------------------------------------
   // clock dividers and data-rate phase
   // ------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!resetn_i || use_sclk_internal_clock || internal_clock_tick) begin
         icnt <= '0;
      end else begin
         icnt <= icnt + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         mcnt <= '0;
      end else if (internal_clock_tick) begin
         mcnt <= mod_tick ? '0 : mcnt + 1'b1;
      end
   end

   // a bad fall realigns the data-rate phase
   always_ff @(posedge clock_i) begin
      if (!resetn_i || resync) begin
         phase <= '0;
      end else if (mod_tick) begin
         phase <= phase + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         sync_loss <= 1'b0;
         filt_rst_q <= 1'b0;
      end else begin
         sync_loss <= resync || (sync_loss && !sync_loss_clear_i);
         filt_rst_q <= resync;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         sclk_gen <= SCLK_RESET;
      end else if (is_master && internal_clock_tick) begin
         sclk_gen <= !sclk_gen;
      end
   end

   // ------------------------------------------------------------
   // frame control
   // ------------------------------------------------------------
   // load opens master frame
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         frame_on <= 1'b0;
      end else if (master_end) begin
         frame_on <= 1'b0;
      end else if (load && is_master) begin
         frame_on <= 1'b1;
      end
   end

   // data-ready returns high at frame end in master and async modes only
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         data_ready_strobe_q <= DATA_READY_STROBE_RESET;
      end else if (load) begin
         data_ready_strobe_q <= 1'b0;
      end else if (master_end || (is_async && cs_rise)) begin
         data_ready_strobe_q <= 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i || !active || master_end) begin
         rx_cnt <= '0;
         rx_sh <= '0;
      end else if (fall_ev && !rx_full) begin
         rx_sh <= {rx_sh[FRAME_BITS-2:0], spi_i.din};
         rx_cnt <= rx_cnt + 1'b1;
      end
   end

   // word released only once the frame completed
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cmd_valid_q <= 1'b0;
         cmd_word_q <= '0;
      end else begin
         cmd_valid_q <= (master_end || slave_end) && rx_full;
         if ((master_end || slave_end) && rx_full) begin
            cmd_word_q <= rx_sh;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         tx_sh <= '0;
         tx_cnt <= '0;
         dout_q <= 1'b0;
      end else if (load) begin
         tx_sh <= fifo_data;
         tx_cnt <= '0;
      end else if (!active && !is_master) begin
         tx_cnt <= '0;
      end else if (rise_ev && active && !tx_full) begin
         dout_q <= tx_sh[FRAME_BITS-1];
         tx_sh <= {tx_sh[FRAME_BITS-2:0], 1'b0};
         tx_cnt <= tx_cnt + 1'b1;
      end
   end

   // float when deselected or past LSB
   always_ff @(posedge clock_i) begin
      if (!resetn_i || !active) begin
         dout_oe_q <= 1'b0;
      end else if (rise_ev) begin
         dout_oe_q <= !tx_full;
      end
   end

   // ------------------------------------------------------------
   // pins and status
   // ------------------------------------------------------------
   // pin direction follows mode
   assign spi_o.sclk = sclk_gen;
   assign spi_o.sclk_oe = is_master;
   assign spi_o.dout = dout_q;
   assign spi_o.dout_oe = dout_oe_q;
   assign spi_o.data_ready_strobe = data_ready_strobe_q;
   assign spi_o.data_ready_strobe_oe = is_master || is_async;
   assign command_valid_o = cmd_valid_q;
   assign command_word_o = cmd_word_q;
   assign sync_loss_flag_o = sync_loss;
   assign filter_reset_o = filt_rst_q;
   assign modulator_tick_o = mod_tick;
   assign interface_mode_o = mode;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_mode_fixed;
      @(posedge clock_i) disable iff (!resetn_i)
      mode_locked |=> mode_locked && $stable(mode);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed after lock");

   property p_async_data_ready_strobe_high;
      @(posedge clock_i) disable iff (!resetn_i)
      (is_async && cs_rise) |=> spi_o.data_ready_strobe;
   endproperty
   a_async_data_ready_strobe_high: assert property (p_async_data_ready_strobe_high) else $error("data_ready_strobe not high");

   property p_master_drives;
      @(posedge clock_i) disable iff (!resetn_i)
      is_master |-> spi_o.sclk_oe && spi_o.data_ready_strobe_oe;
   endproperty
   a_master_drives: assert property (p_master_drives) else $error("master pin not driven");

   property p_master_sclk_runs;
      @(posedge clock_i) disable iff (!resetn_i)
      (is_master && internal_clock_tick) |=> (spi_o.sclk != $past(spi_o.sclk));
   endproperty
   a_master_sclk_runs: assert property (p_master_sclk_runs) else $error("sclk stalled");

   property p_rx_on_fall;
      @(posedge clock_i) disable iff (!resetn_i)
      (active && !fall_ev && !master_end) |=> $stable(rx_cnt);
   endproperty
   a_rx_on_fall: assert property (p_rx_on_fall) else $error("rx moved off falling edge");

   property p_cmd_after_frame;
      @(posedge clock_i) disable iff (!resetn_i)
      command_valid_o |-> $past(rx_full) && $past(master_end || slave_end);
   endproperty
   a_cmd_after_frame: assert property (p_cmd_after_frame) else $error("early command");

   property p_dout_on_rise;
      @(posedge clock_i) disable iff (!resetn_i)
      (spi_o.dout != $past(spi_o.dout)) |-> $past(rise_ev);
   endproperty
   a_dout_on_rise: assert property (p_dout_on_rise) else $error("dout moved off rise");

   property p_cs_floats;
      @(posedge clock_i) disable iff (!resetn_i)
      (!is_master && spi_i.cs_n) |=> !spi_o.dout_oe;
   endproperty
   a_cs_floats: assert property (p_cs_floats) else $error("dout driven while deselected");

   property p_master_data_ready_strobe_low;
      @(posedge clock_i) disable iff (!resetn_i)
      (is_master && load) |=> !spi_o.data_ready_strobe ##0 frame_on;
   endproperty
   a_master_data_ready_strobe_low: assert property (p_master_data_ready_strobe_low) else $error("data_ready_strobe not low");

   property p_master_data_ready_strobe_end;
      @(posedge clock_i) disable iff (!resetn_i)
      master_end |-> $past(tx_full) ##1 (spi_o.data_ready_strobe && !frame_on);
   endproperty
   a_master_data_ready_strobe_end: assert property (p_master_data_ready_strobe_end) else $error("frame not closed");

   property p_slave_inputs;
      @(posedge clock_i) disable iff (!resetn_i)
      is_slave |-> !spi_o.sclk_oe && !spi_o.data_ready_strobe_oe;
   endproperty
   a_slave_inputs: assert property (p_slave_inputs) else $error("slave drives input pin");

   property p_resync;
      @(posedge clock_i) disable iff (!resetn_i)
      resync |=> sync_loss_flag_o && filter_reset_o && (phase == PHASE_ZERO);
   endproperty
   a_resync: assert property (p_resync) else $error("resync not flagged");

   c_master_frame: cover property (@(posedge clock_i) disable iff (!resetn_i) master_end);
   c_async_cmd: cover property (@(posedge clock_i) disable iff (!resetn_i)
      is_async && command_valid_o);
   c_slave_resync: cover property (@(posedge clock_i) disable iff (!resetn_i) resync);
endmodule

//--- adc_spi_pkg.sv
// Purpose: shared constants and carrier types for the ADC serial frame block
// Assumes: one 24-bit device word per frame, 20 MHz system clock
// Notes: pin groups travel as packed structs
package adc_spi_pkg;

   localparam int FRAME_BITS = 24;
   localparam int CNT_W = 5;
   localparam logic [4:0] FRAME_BITS_CNT = 5'h18;
   localparam int DIV_W = 3;

   // modulator clocks per conversion result
   localparam int PHASE_W = 4;
   localparam logic [3:0] PHASE_LAST = 4'hF;
   localparam logic [3:0] PHASE_ZERO = 4'h0;

   localparam int FIFO_DEPTH = 8;

   // reset values
   localparam logic DATA_READY_STROBE_RESET = 1'b1;
   localparam logic SCLK_RESET = 1'b0;
   localparam logic CS_N_RESET = 1'b1;

   typedef enum logic [1:0] {
      MODE_ASYNC,
      MODE_MASTER,
      MODE_SLAVE
   } interface_mode_type;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
      logic data_ready_strobe;
   } spi_in_type;

   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic dout;
      logic dout_oe;
      logic data_ready_strobe;
      logic data_ready_strobe_oe;
   } spi_out_type;

endpackage

//--- sample_fifo.sv
// Purpose: conversion word buffer between sample source and output shifter
// Assumes: single clock, first-word-fall-through read
// Notes: one extra pointer bit tells full from empty
`timescale 1ns/1ns
module sample_fifo #(
   parameter int WIDTH = adc_spi_pkg::FRAME_BITS,
   parameter int DEPTH = adc_spi_pkg::FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = (wr_ptr == rd_ptr);
   wire push = in_valid_i && !full;
   wire pop = !empty && out_ready_i;

   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

//--- spi_host_model.sv
// Purpose: host controller model for the ADC serial port
// Assumes: host pins move just after a clock edge, sclk levels held 4 clocks in frame, 2 in run_clocks
// Notes: din toggles while idle so stale data never looks valid
`timescale 1ns/1ns
module spi_host_model (
   input wire logic clock_i,
   input wire adc_spi_pkg::spi_out_type dev_i,
   output adc_spi_pkg::spi_in_type pins_o
);
   import adc_spi_pkg::*;
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   logic busy = 1'b0;
   initial pins_o = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, data_ready_strobe: 1'b1};
   always @(posedge clock_i) begin
      if (!busy) pins_o.din <= ~pins_o.din;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 3000 && dev_i.data_ready_strobe !== 1'b0; i++) @(posedge clock_i);
   endtask
   task automatic select(input logic on);
      @(posedge clock_i);
      pins_o.cs_n <= ~on;
      if (!on) busy = 1'b0;
   endtask
   task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx,
                        output logic oe_ok);
      rx = 24'h000000;
      oe_ok = 1'b1;
      busy = 1'b1;
      select(1'b1);
      step(2);
      for (int b = 0; b < nbits + (nbits == 24); b++) begin
         pins_o.sclk <= 1'b1;
         pins_o.din <= (b < 24) ? tx[23-b] : ~tx[0];
         step(4);
         if (b < 24) rx[23-b] = dev_i.dout;
         if (b < 24) oe_ok &= (dev_i.dout_oe === 1'b1);
         pins_o.sclk <= 1'b0;
         step(4);
      end
   endtask
   task automatic wait_sclk(input logic lvl);
      logic prev;
      prev = dev_i.sclk;
      for (int i = 0; i < 200; i++) begin
         @(posedge clock_i);
         if (prev === ~lvl && dev_i.sclk === lvl) break;
         prev = dev_i.sclk;
      end
   endtask
   task automatic master_frame(input logic [23:0] tx, output logic [23:0] rx);
      rx = 24'h000000;
      busy = 1'b1;
      wait_ready();
      for (int b = 0; b < 24; b++) begin
         wait_sclk(1'b1);
         pins_o.din <= tx[23-b];
         wait_sclk(1'b0);
         // a released line reads back inverted so stale bits show up
         rx[23-b] = (dev_i.dout_oe === 1'b1) ? dev_i.dout : ~dev_i.dout;
      end
      busy = 1'b0;
   endtask
   task automatic run_clocks(input int n);
      repeat (n) begin
         pins_o.sclk <= 1'b1;
         step(2);
         pins_o.sclk <= 1'b0;
         step(2);
      end
   endtask
   task automatic set_data_ready_strobe(input logic v);
      pins_o.data_ready_strobe <= v;
   endtask
endmodule

//--- test_adc_spi_frame.sv
// Purpose: self-checking bench for the ADC serial frame block
// Assumes: host model drives the pins, bench drives the rest
// Notes: dividers kept small so update ticks come quickly
`timescale 1ns/1ns
module test_adc_spi_frame;
   import adc_spi_pkg::*;
   // ----------------------------------------
   // stimulus and monitors
   // ----------------------------------------
   logic clock_i;
   logic resetn_i;
   logic strap;
   logic strap_float;
   logic src_sel;
   logic [2:0] idiv;
   logic [2:0] mdiv;
   logic flag_clear;
   logic push;
   logic [23:0] push_data;
   spi_in_type pins;
   spi_out_type dev;
   logic ready, cmd_valid, flag, frst, tick, seen;
   logic [23:0] cmd_word, got, tx;
   interface_mode_type mode;
   int errors = 0;
   int total_checks = 0;
   int ticks = 0;
   int gap = 0;
   int since = 0;
   int base = 0;
   int t = 0;
   time t0;
   logic [23:0] cmds[$];
   logic [23:0] words[$];
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   adc_spi_frame adc_spi_frame_inst (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .interface_mode_pin_i(strap),
      .interface_mode_pin_float_i(strap_float),
      .internal_clock_source_select_i(src_sel),
      .internal_clock_divider_i(idiv),
      .modulator_clock_divider_i(mdiv),
      .sync_loss_clear_i(flag_clear),
      .spi_i(pins),
      .spi_o(dev),
      .sample_valid_i(push),
      .sample_ready_o(ready),
      .sample_data_i(push_data),
      .command_valid_o(cmd_valid),
      .command_word_o(cmd_word),
      .sync_loss_flag_o(flag),
      .filter_reset_o(frst),
      .modulator_tick_o(tick),
      .interface_mode_o(mode)
   );
   spi_host_model spi_host_model_inst (.clock_i(clock_i), .dev_i(dev), .pins_o(pins));
   always @(posedge clock_i) begin
      if (cmd_valid === 1'b1) cmds.push_back(cmd_word);
      if (tick === 1'b1) begin
         ticks <= ticks + 1;
         gap <= since + 1;
         since <= 0;
      end else begin
         since <= since + 1;
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen_v);
      total_checks++;
      if (seen_v !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen_v);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // strap flips after the latch to prove it is sampled once
   task automatic do_reset(input logic lvl, input logic flt);
      @(posedge clock_i);
      resetn_i <= 1'b0;
      strap <= lvl;
      strap_float <= flt;
      words.delete();
      cmds.delete();
      repeat (20) @(posedge clock_i);
      resetn_i <= 1'b1;
      base = ticks;
      repeat (3) @(posedge clock_i);
      strap <= ~lvl;
      strap_float <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic push_word(input logic [23:0] w);
      @(posedge clock_i);
      push <= 1'b1;
      push_data <= w;
      words.push_back(w);
      @(posedge clock_i);
      for (int i = 0; i < 50 && ready !== 1'b1; i++) @(posedge clock_i);
      push <= 1'b0;
   endtask
   task automatic read_frame(input int nbits);
      logic [23:0] txw;
      logic [23:0] rx;
      logic oe;
      txw = 24'($urandom);
      if (mode === MODE_ASYNC) spi_host_model_inst.wait_ready();
      spi_host_model_inst.frame(txw, nbits, rx, oe);
      check("early command", 0, cmds.size());
      if (nbits == 24) begin
         check("read word", words.pop_front(), rx);
         check("oe in frame", 1, oe);
         check("oe after lsb", 0, dev.dout_oe);
      end
      spi_host_model_inst.select(1'b0);
      // the high level may last one cycle only when a word is waiting
      seen = 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock_i);
         seen |= (dev.data_ready_strobe === 1'b1);
      end
      if (mode === MODE_ASYNC) check("data_ready_strobe after frame", 1, seen);
      check("dout float", 0, dev.dout_oe);
      check("commands", nbits == 24, cmds.size());
      if (cmds.size() > 0) check("command word", txw, cmds.pop_front());
   endtask
   task automatic wait_ticks(input int target);
      for (int i = 0; i < 3000 && ticks - base != target; i++) @(posedge clock_i);
   endtask
   initial begin
      repeat (60000) @(posedge clock_i);
      errors++;
      print_verdict();
   end
   initial begin
      resetn_i <= 1'b0;
      strap <= 1'b1;
      strap_float <= 1'b0;
      src_sel <= 1'b0;
      idiv <= 3'h0;
      mdiv <= 3'h0;
      flag_clear <= 1'b0;
      push <= 1'b0;
      push_data <= 24'h000000;
      void'($urandom(99305));
      do_reset(1'b1, 1'b0);
      check("mode", MODE_ASYNC, mode);
      check("async pins", 32'hC, {dev.data_ready_strobe, dev.data_ready_strobe_oe, dev.sclk_oe, dev.dout_oe});
      for (int k = 0; k < 3; k++) begin
         @(posedge clock_i);
         idiv <= 3'($urandom);
         mdiv <= 3'($urandom);
         repeat (150) @(posedge clock_i);
         check("tick gap", (idiv + 1) * (mdiv + 1), gap);
      end
      idiv <= 3'h0;
      mdiv <= 3'h0;
      // select held low keeps the buffer from draining
      spi_host_model_inst.select(1'b1);
      for (int k = 0; k < FIFO_DEPTH; k++) push_word(24'($urandom));
      @(posedge clock_i);
      check("fifo full", 0, ready);
      push <= 1'b1;
      repeat (4) @(posedge clock_i);
      push <= 1'b0;
      check("push refused", 0, ready);
      spi_host_model_inst.select(1'b0);
      for (int k = 0; k < FIFO_DEPTH; k++) read_frame(24);
      push_word(24'($urandom));
      read_frame(10);
      // master: a result every 256 clocks, a frame needs about 200
      idiv <= 3'h3;
      mdiv <= 3'h3;
      do_reset(1'b0, 1'b0);
      check("mode", MODE_MASTER, mode);
      repeat (100) @(posedge clock_i);
      check("master pins", 32'h3, {dev.sclk_oe, dev.data_ready_strobe_oe});
      check("no data no frame", 1, dev.data_ready_strobe);
      spi_host_model_inst.wait_sclk(1'b1);
      t0 = $time;
      spi_host_model_inst.wait_sclk(1'b1);
      check("sclk period", 8, 32'(($time - t0) / 50));
      push_word(24'($urandom));
      push_word(24'($urandom));
      for (int k = 0; k < 2; k++) begin
         tx = 24'($urandom);
         spi_host_model_inst.master_frame(tx, got);
         check("master word", words.pop_front(), got);
         for (int i = 0; i < 4 && dev.data_ready_strobe !== 1'b1; i++) @(posedge clock_i);
         check("data_ready_strobe after lsb", 1, dev.data_ready_strobe);
         repeat (3) @(posedge clock_i);
         check("master commands", 1, cmds.size());
         if (cmds.size() > 0) check("master command", tx, cmds.pop_front());
      end
      repeat (10) @(posedge clock_i);
      check("master oe after lsb", 0, dev.dout_oe);
      idiv <= 3'h1;
      mdiv <= 3'h3;
      do_reset(1'b0, 1'b1);
      check("mode", MODE_SLAVE, mode);
      check("slave pins", 0, {dev.sclk_oe, dev.data_ready_strobe_oe, dev.dout_oe});
      push_word(24'($urandom));
      repeat (300) @(posedge clock_i);
      read_frame(24);
      wait_ticks(((ticks - base) / 16 + 1) * 16 + 5);
      spi_host_model_inst.set_data_ready_strobe(1'b0);
      for (int i = 0; i < 6 && frst !== 1'b1; i++) @(posedge clock_i);
      check("filter reset", 1, frst);
      base = ticks;
      @(posedge clock_i);
      spi_host_model_inst.set_data_ready_strobe(1'b1);
      check("sync flag", 1, flag);
      flag_clear <= 1'b1;
      @(posedge clock_i);
      flag_clear <= 1'b0;
      repeat (2) @(posedge clock_i);
      check("flag cleared", 0, flag);
      wait_ticks(16);
      spi_host_model_inst.set_data_ready_strobe(1'b0);
      seen = 1'b0;
      repeat (10) begin
         @(posedge clock_i);
         seen |= (frst !== 1'b0);
      end
      check("no resync", 0, seen);
      check("flag stays clear", 0, flag);
      spi_host_model_inst.set_data_ready_strobe(1'b1);
      src_sel <= 1'b1;
      repeat (20) @(posedge clock_i);
      t = ticks;
      repeat (50) @(posedge clock_i);
      check("idle sclk no ticks", t, ticks);
      spi_host_model_inst.run_clocks(24);
      repeat (4) @(posedge clock_i);
      check("ticks from sclk", t + 6, ticks);
      print_verdict();
   end
endmodule
